// ### etc_timer_core.sv
// Top of the 8-bit timer/counter core: APB register file, counter unit,
// two compare units with double buffering, flags and masked requests.
// Assumes a zero-wait APB master on the same clock and an asynchronous event pin.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "etc_params.svh"

// How it works
// - Count and compare registers are eight bits
// - Bottom indicated when count equals zero
// - Max indicated when count equals 0xFF
// - Top is 0xFF or compare A
// - Clock select picks prescaler or pin edge
// - Clock select zero stops the counter
// - Each tick clears, increments or decrements
// - Clear forces all count bits low
// - Top and bottom status signals provided
// - CPU reads and writes count anytime
// - CPU count write beats clear and count
// - Mode field split over both controls
// - Overflow flag set depending on mode
// - Compares run continuously toward waveform logic
// - Match sets compare flag A or B
// - Flags in one register, individually masked
// - Compare registers double buffered in PWM
// - Normal mode wraps, overflow at zero
// - CTC mode clears count on compare A
// - Compare flag set on following tick
// - Count write blocks next tick's matches
module etc_timer_core (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External event pin
  input wire logic extEventPin,
  // Status toward the waveform generator
  output logic timerTickOut,
  output logic matchA,
  output logic matchB,
  output logic atTop,
  output logic atBottom,
  output logic atMax,
  output logic countDown,
  // Masked requests
  output logic overflowRequest,
  output logic compareRequestA,
  output logic compareRequestB
);
  import etc_pkg::*;

  // Register state; all software-visible except the comparator-side compare values
  logic [1:0] waveModeLow; // Waveform mode bits 1:0, control A
  logic waveModeBit2; // Waveform mode bit 2, control B
  etc_clock_sel_t clockSelectField; // Clock source, control B
  logic [7:0] countValue; // Counter
  logic [7:0] compareBufA; // CPU side of compare A
  logic [7:0] compareBufB; // CPU side of compare B
  logic [7:0] compareValueA; // Compare A as used by the comparator
  logic [7:0] compareValueB; // Compare B as used by the comparator
  logic [2:0] timerFlagRegister; // Overflow, compare A, compare B
  logic [2:0] timerMaskRegister; // Matching enables
  logic timerPowerReductionBit; // High keeps the block asleep

  // Internal state and strobes
  logic timerTick; // One-cycle tick from the clock selector
  logic blockMatch; // Set by a count write, cleared by the next tick
  etc_wave_mode_t waveMode;
  logic [7:0] topValue;
  logic apbWrite;
  logic writeCount;
  logic writeCompareA;
  logic writeCompareB;
  logic [7:0] next_count;
  logic next_down;
  logic clearCount;
  logic bufferLoad;
  logic setOverflow;
  logic matchEventA;
  logic matchEventB;
  logic [7:0] next_bufA;
  logic [7:0] next_bufB;
  logic [7:0] next_cmpA;
  logic [7:0] next_cmpB;
  logic [2:0] next_flags;
  logic [2:0] flagClear;
  logic [31:0] readData;

  // PWM modes are the odd codes; they alone use buffered compares
  function automatic logic isPwm(input etc_wave_mode_t mode);
    isPwm = mode[0];
  endfunction

  // Phase-correct modes count up and down
  function automatic logic isPhase(input etc_wave_mode_t mode);
    isPhase = (mode == ETC_WAVE_PC_MAX) || (mode == ETC_WAVE_PC_CMPA);
  endfunction

  // Top of the sequence for a mode
  function automatic logic [7:0] topOf(input etc_wave_mode_t mode, input logic [7:0] cmpA);
    case (mode)
      ETC_WAVE_CTC, ETC_WAVE_PC_CMPA, ETC_WAVE_FAST_CMPA: topOf = cmpA;
      default: topOf = `ETC_MAX;
    endcase
  endfunction

  // Word-aligned decode of the register window
  function automatic logic addrMapped(input logic [7:0] addr);
    case (addr)
      `ETC_OFF_CONTROL_A, `ETC_OFF_CONTROL_B, `ETC_OFF_COUNT,
      `ETC_OFF_COMPARE_A, `ETC_OFF_COMPARE_B, `ETC_OFF_FLAGS,
      `ETC_OFF_MASK, `ETC_OFF_POWER: addrMapped = 1'b1;
      default: addrMapped = 1'b0;
    endcase
  endfunction

  assign waveMode = etc_wave_mode_t'({waveModeBit2, waveModeLow});
  assign topValue = topOf(waveMode, compareValueA);

  // Write strobes fire only at the completing access edge
  assign apbWrite = psel && penable && pwrite && pready;
  assign writeCount = apbWrite && (paddr == `ETC_OFF_COUNT);
  assign writeCompareA = apbWrite && (paddr == `ETC_OFF_COMPARE_A);
  assign writeCompareB = apbWrite && (paddr == `ETC_OFF_COMPARE_B);

  // Tick source; the selector owns synchronisation and the power gate
  etc_clock_select clockSelect (
    .clock(clock),
    .rstn(rstn),
    .powerDown(timerPowerReductionBit),
    .clockSel(clockSelectField),
    .extEventPin(extEventPin),
    .timerTick(timerTick)
  );

  // Counter unit: next value and direction
  always_comb begin
    next_count = countValue;
    next_down = countDown;
    clearCount = 1'b0;
    if (timerTick) begin
      if (isPhase(waveMode)) begin
        if (topValue == `ETC_BOTTOM) begin
          clearCount = 1'b1; // Degenerate top: sit at zero
          next_down = 1'b0;
        end else if (!countDown) begin
          if (countValue == topValue) begin
            next_down = 1'b1;
            next_count = countValue - 8'h01;
          end else begin
            next_count = countValue + 8'h01;
          end
        end else begin
          if (countValue == `ETC_BOTTOM) begin
            next_down = 1'b0;
            next_count = countValue + 8'h01;
          end else begin
            next_count = countValue - 8'h01;
          end
        end
      end else begin
        next_down = 1'b0;
        if (countValue == topValue) begin
          clearCount = 1'b1;
        end else begin
          next_count = countValue + 8'h01;
        end
      end
    end
    if (clearCount) begin
      next_count = `ETC_BOTTOM;
    end
    if (writeCount) begin
      next_count = pwdata[7:0];
    end
  end

  // Counter register; software access needs no tick
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      countValue <= `ETC_RESET_BYTE;
      countDown <= 1'b0;
    end else begin
      countValue <= next_count;
      countDown <= next_down;
    end
  end

  // Overflow condition per mode; a coinciding count write cancels the event
  always_comb begin
    setOverflow = 1'b0;
    if (timerTick && !writeCount) begin
      case (waveMode)
        ETC_WAVE_FAST_MAX, ETC_WAVE_FAST_CMPA: setOverflow = countValue == topValue;
        ETC_WAVE_PC_MAX, ETC_WAVE_PC_CMPA: setOverflow = countDown && countValue == `ETC_BOTTOM;
        default: setOverflow = !countDown && countValue == `ETC_MAX;
      endcase
    end
  end

  // Buffer reload point: bottom for fast PWM, top for phase correct
  assign bufferLoad = timerTick && isPwm(waveMode) && countValue == topValue
    && (!isPhase(waveMode) || !countDown);

  // Match seen on the tick after the counter sat on the value
  assign matchEventA = timerTick && !blockMatch && countValue == compareValueA;
  assign matchEventB = timerTick && !blockMatch && countValue == compareValueB;

  // Match blocking after a count write, held even with no clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      blockMatch <= 1'b0;
    end else if (writeCount) begin
      blockMatch <= 1'b1;
    end else if (timerTick) begin
      blockMatch <= 1'b0;
    end
  end

  // Compare values: CPU side and comparator side
  always_comb begin
    next_bufA = writeCompareA ? pwdata[7:0] : compareBufA;
    next_bufB = writeCompareB ? pwdata[7:0] : compareBufB;
    // Non-PWM modes write through so a new value acts at once
    next_cmpA = (!isPwm(waveMode) || bufferLoad) ? next_bufA : compareValueA;
    next_cmpB = (!isPwm(waveMode) || bufferLoad) ? next_bufB : compareValueB;
  end

  // Compare registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      compareBufA <= `ETC_RESET_BYTE;
      compareBufB <= `ETC_RESET_BYTE;
      compareValueA <= `ETC_RESET_BYTE;
      compareValueB <= `ETC_RESET_BYTE;
    end else begin
      compareBufA <= next_bufA;
      compareBufB <= next_bufB;
      compareValueA <= next_cmpA;
      compareValueB <= next_cmpB;
    end
  end

  // Flags: write one to clear, and a same-cycle event wins over the clear
  always_comb begin
    flagClear = (apbWrite && paddr == `ETC_OFF_FLAGS) ? pwdata[`ETC_FLAG_MSB:0] : 3'h0;
    next_flags = timerFlagRegister & ~flagClear;
    if (setOverflow) begin
      next_flags[`ETC_FLAG_OVERFLOW] = 1'b1;
    end
    if (matchEventA) begin
      next_flags[`ETC_FLAG_COMPARE_A] = 1'b1;
    end
    if (matchEventB) begin
      next_flags[`ETC_FLAG_COMPARE_B] = 1'b1;
    end
  end

  // Flag register and masked requests
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timerFlagRegister <= `ETC_RESET_FLAGS;
      overflowRequest <= 1'b0;
      compareRequestA <= 1'b0;
      compareRequestB <= 1'b0;
    end else begin
      timerFlagRegister <= next_flags;
      overflowRequest <= next_flags[`ETC_FLAG_OVERFLOW] && timerMaskRegister[`ETC_FLAG_OVERFLOW];
      compareRequestA <= next_flags[`ETC_FLAG_COMPARE_A]
        && timerMaskRegister[`ETC_FLAG_COMPARE_A];
      compareRequestB <= next_flags[`ETC_FLAG_COMPARE_B]
        && timerMaskRegister[`ETC_FLAG_COMPARE_B];
    end
  end

  // Control, mask and power registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      waveModeLow <= 2'h0;
      waveModeBit2 <= 1'b0;
      clockSelectField <= ETC_CLK_OFF;
      timerMaskRegister <= `ETC_RESET_FLAGS;
      timerPowerReductionBit <= `ETC_RESET_POWER;
    end else if (apbWrite) begin
      case (paddr)
        `ETC_OFF_CONTROL_A: waveModeLow <= pwdata[`ETC_CTLA_WAVE_MSB:`ETC_CTLA_WAVE_LSB];
        `ETC_OFF_CONTROL_B: begin
          clockSelectField <= etc_clock_sel_t'(pwdata[`ETC_CTLB_CLKSEL_MSB:`ETC_CTLB_CLKSEL_LSB]);
          waveModeBit2 <= pwdata[`ETC_CTLB_WAVE_BIT2];
        end
        `ETC_OFF_MASK: timerMaskRegister <= pwdata[`ETC_FLAG_MSB:0];
        `ETC_OFF_POWER: timerPowerReductionBit <= pwdata[`ETC_POWER_BIT];
        default: begin
          // Other offsets are stored elsewhere or unmapped
        end
      endcase
    end
  end

  // Read multiplexer; compares read back the CPU side
  always_comb begin
    readData = 32'h0000_0000;
    case (paddr)
      `ETC_OFF_CONTROL_A: readData[`ETC_CTLA_WAVE_MSB:`ETC_CTLA_WAVE_LSB] = waveModeLow;
      `ETC_OFF_CONTROL_B: begin
        readData[`ETC_CTLB_CLKSEL_MSB:`ETC_CTLB_CLKSEL_LSB] = clockSelectField;
        readData[`ETC_CTLB_WAVE_BIT2] = waveModeBit2;
      end
      `ETC_OFF_COUNT: readData[7:0] = countValue;
      `ETC_OFF_COMPARE_A: readData[7:0] = compareBufA;
      `ETC_OFF_COMPARE_B: readData[7:0] = compareBufB;
      `ETC_OFF_FLAGS: readData[`ETC_FLAG_MSB:0] = timerFlagRegister;
      `ETC_OFF_MASK: readData[`ETC_FLAG_MSB:0] = timerMaskRegister;
      `ETC_OFF_POWER: readData[`ETC_POWER_BIT] = timerPowerReductionBit;
      default: readData = 32'h0000_0000;
    endcase
  end

  // APB answer: data captured in setup, so the access phase needs no wait
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : readData;
        pslverr <= !addrMapped(paddr);
      end else if (!psel) begin
        pslverr <= 1'b0;
      end
    end
  end

  // Status toward the waveform logic, aligned with the counter register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timerTickOut <= 1'b0;
      matchA <= 1'b0;
      matchB <= 1'b0;
      atTop <= 1'b0;
      atBottom <= 1'b0;
      atMax <= 1'b0;
    end else begin
      timerTickOut <= timerTick;
      matchA <= next_count == next_cmpA;
      matchB <= next_count == next_cmpB;
      atTop <= next_count == topOf(waveMode, next_cmpA);
      atBottom <= next_count == `ETC_BOTTOM;
      atMax <= next_count == `ETC_MAX;
    end
  end

endmodule // etc_timer_core

`default_nettype wire

// ### etc_params.svh
// Constants of the 8-bit timer/counter core: register offsets, field positions,
// reset values and prescaler taps.
// Assumes it is included by bare name from each design file that needs it.
`ifndef ETC_PARAMS_SVH
`define ETC_PARAMS_SVH

// Register byte offsets on the APB window
`define ETC_OFF_CONTROL_A 8'h00
`define ETC_OFF_CONTROL_B 8'h04
`define ETC_OFF_COUNT 8'h08
`define ETC_OFF_COMPARE_A 8'h0c
`define ETC_OFF_COMPARE_B 8'h10
`define ETC_OFF_FLAGS 8'h14
`define ETC_OFF_MASK 8'h18
`define ETC_OFF_POWER 8'h1c

// Field positions
`define ETC_CTLA_WAVE_MSB 1
`define ETC_CTLA_WAVE_LSB 0
`define ETC_CTLB_CLKSEL_MSB 2
`define ETC_CTLB_CLKSEL_LSB 0
`define ETC_CTLB_WAVE_BIT2 3
`define ETC_FLAG_OVERFLOW 0
`define ETC_FLAG_COMPARE_A 1
`define ETC_FLAG_COMPARE_B 2
`define ETC_FLAG_MSB 2
`define ETC_POWER_BIT 0

// Counter limits
`define ETC_BOTTOM 8'h00
`define ETC_MAX 8'hff

// Reset values
`define ETC_RESET_BYTE 8'h00
`define ETC_RESET_FLAGS 3'h0
`define ETC_RESET_POWER 1'b1

// Prescaler tap masks: a tick fires when all masked bits are one
`define ETC_TAP_DIV8 10'h007
`define ETC_TAP_DIV64 10'h03f
`define ETC_TAP_DIV256 10'h0ff
`define ETC_TAP_DIV1024 10'h3ff

`endif

// ### etc_pkg.sv
// Types shared by the timer/counter core and its clock selector.
// Assumes it is compiled before every design module.
package etc_pkg;

  // Counting sequence selected by the three-bit waveform mode field
  typedef enum logic [2:0] {
    ETC_WAVE_NORMAL = 3'h0,
    ETC_WAVE_PC_MAX = 3'h1,
    ETC_WAVE_CTC = 3'h2,
    ETC_WAVE_FAST_MAX = 3'h3,
    ETC_WAVE_RSV4 = 3'h4,
    ETC_WAVE_PC_CMPA = 3'h5,
    ETC_WAVE_RSV6 = 3'h6,
    ETC_WAVE_FAST_CMPA = 3'h7
  } etc_wave_mode_t;

  // Timer clock source
  typedef enum logic [2:0] {
    ETC_CLK_OFF = 3'h0,
    ETC_CLK_DIV1 = 3'h1,
    ETC_CLK_DIV8 = 3'h2,
    ETC_CLK_DIV64 = 3'h3,
    ETC_CLK_DIV256 = 3'h4,
    ETC_CLK_DIV1024 = 3'h5,
    ETC_CLK_EXT_FALL = 3'h6,
    ETC_CLK_EXT_RISE = 3'h7
  } etc_clock_sel_t;

endpackage

// ### etc_clock_select.sv
// Clock selector of the timer: prescaler taps and external event edge detector.
// Assumes one system clock; the event pin is asynchronous to it.
`timescale 1ns/1ns
`default_nettype none
`include "etc_params.svh"

module etc_clock_select (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Control
  input wire logic powerDown,
  input wire etc_pkg::etc_clock_sel_t clockSel,
  // External event pin
  input wire logic extEventPin,
  // One-cycle timer tick
  output logic timerTick
);
  import etc_pkg::*;

  logic extSync1; // First synchroniser stage, read only by extSync2
  logic extSync2; // Synchronised pin level
  logic extLast; // Previous synchronised level, for edge detection
  logic [9:0] prescale; // Free divider of the system clock
  logic next_tick;

  // All taps share one test, so it lives in a function
  function automatic logic tapHit(input logic [9:0] value, input logic [9:0] mask);
    tapHit = (value & mask) == mask;
  endfunction

  // Two-stage synchroniser plus a history stage for edge detection
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extLast <= 1'b0;
    end else begin
      extSync1 <= extEventPin;
      extSync2 <= extSync1;
      extLast <= extSync2;
    end
  end

  // Divider held at zero while stopped, so a restart begins a full period
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prescale <= 10'h000;
    end else if (powerDown || clockSel == ETC_CLK_OFF) begin
      prescale <= 10'h000;
    end else begin
      prescale <= prescale + 10'h001;
    end
  end

  // Source and edge choice
  always_comb begin
    case (clockSel)
      ETC_CLK_OFF: next_tick = 1'b0;
      ETC_CLK_DIV1: next_tick = 1'b1;
      ETC_CLK_DIV8: next_tick = tapHit(prescale, `ETC_TAP_DIV8);
      ETC_CLK_DIV64: next_tick = tapHit(prescale, `ETC_TAP_DIV64);
      ETC_CLK_DIV256: next_tick = tapHit(prescale, `ETC_TAP_DIV256);
      ETC_CLK_DIV1024: next_tick = tapHit(prescale, `ETC_TAP_DIV1024);
      ETC_CLK_EXT_FALL: next_tick = extLast && !extSync2;
      ETC_CLK_EXT_RISE: next_tick = !extLast && extSync2;
      default: next_tick = 1'b0;
    endcase
  end

  // Registered tick; the power gate holds the tick and the divider, while the synchroniser keeps sampling
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timerTick <= 1'b0;
    end else begin
      timerTick <= next_tick && !powerDown;
    end
  end

endmodule // etc_clock_select

`default_nettype wire

// ### etc_timer_core_props.sv
// Checker for the timer core: sees only the top-level ports.
// Assumes one clock domain and the register offsets of the shared header.
`timescale 1ns/1ns
`default_nettype none
`include "etc_params.svh"

module etc_timer_core_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Status and requests
  input wire logic timerTickOut,
  input wire logic atBottom,
  input wire logic atMax,
  input wire logic overflowRequest,
  input wire logic compareRequestA
);
  logic [1:0] upCnt; // Edges since reset, saturating
  logic [2:0] stopCnt; // Cycles since clock select went to zero
  logic wrAcc; // APB write in its access cycle
  logic cntWr; // Count write taking effect
  logic flagWr; // Flag clear write
  logic maskWr; // Mask write
  logic wrZero; // Written byte is bottom
  logic wrFull; // Written byte is max

  assign wrAcc = psel && penable && pwrite;
  assign cntWr = wrAcc && paddr == `ETC_OFF_COUNT;
  assign flagWr = wrAcc && paddr == `ETC_OFF_FLAGS;
  assign maskWr = wrAcc && paddr == `ETC_OFF_MASK;
  assign wrZero = pwdata[7:0] == 8'h00;
  assign wrFull = pwdata[7:0] == 8'hff;

  // Masks out the first edges, where sampled history still holds reset values
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) upCnt <= 2'h0;
    else if (upCnt != 2'h3) upCnt <= upCnt + 2'h1;
  end

  // Clock select resets to off; 0 means running, 7 means stopped long enough
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stopCnt <= 3'h7;
    end else if (wrAcc && paddr == `ETC_OFF_CONTROL_B) begin
      stopCnt <= (pwdata[2:0] == 3'h0) ? 3'h1 : 3'h0;
    end else if (stopCnt != 3'h0 && stopCnt != 3'h7) begin
      stopCnt <= stopCnt + 3'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  chk_bot_max: assert property (!(atBottom && atMax))
    else $error("bottom and max high together");
  chk_cnt_hold: assert property (upCnt == 2'h3 && ($changed(atBottom) || $changed(atMax))
    |-> timerTickOut || $past(cntWr)) else $error("count moved without tick or write");
  chk_wr_wins: assert property (cntWr |=> atBottom == $past(wrZero) && atMax == $past(wrFull))
    else $error("count write did not win");
  chk_ovf_rise: assert property ($rose(overflowRequest)
    |-> timerTickOut || $past(timerTickOut) || $past(maskWr) || $past(maskWr, 2))
    else $error("overflow request without tick or mask");
  chk_cmpa_rise: assert property ($rose(compareRequestA)
    |-> timerTickOut || $past(timerTickOut) || $past(maskWr) || $past(maskWr, 2))
    else $error("compare request without tick or mask");
  chk_req_fall: assert property ($fell(overflowRequest)
    |-> $past(flagWr) || $past(flagWr, 2) || $past(maskWr) || $past(maskWr, 2))
    else $error("overflow request dropped by itself");
  chk_ready_on: assert property (upCnt != 2'h0 |-> pready)
    else $error("ready low after reset");
  chk_err_decode: assert property (psel && penable
    |-> pslverr == (paddr > `ETC_OFF_POWER || paddr[1:0] != 2'h0)) else $error("bad error decode");
  chk_rd_high: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  chk_tick_stop: assert property (stopCnt == 3'h7 |-> !timerTickOut)
    else $error("tick while clock select off");

  cover property ($rose(overflowRequest));
  cover property ($rose(compareRequestA));
  cover property (psel && penable && pslverr);
endmodule // etc_timer_core_props
`default_nettype wire

// ### etc_event_src.sv
// Model of the external event source on the timer's event pin.
// Assumes the pin is asynchronous to the system clock and idles low.
`timescale 1ns/1ns
`default_nettype none

module etc_event_src (
  // Event pin toward the timer
  output logic extEventPin
);
  // Pin idles low between bursts
  initial extEventPin = 1'b0;

  // Emit n pulses; slow mode stretches each level. Odd widths put every other
  // edge off the 4 ns clock grid; the edges between them can land on it.
  task automatic burst(input int n, input bit slow);
    int w;
    w = slow ? 63 : 13;
    repeat (n) begin
      #(w) extEventPin = 1'b1;
      #(w) extEventPin = 1'b0;
    end
    #(w);
  endtask
endmodule // etc_event_src
`default_nettype wire

// ### etc_timer_core_tb.sv
// Self-checking bench for the timer core: APB master, event source, checker.
// Assumes a zero-wait APB slave and the offsets of the shared header.
`timescale 1ns/1ns
`default_nettype none
`include "etc_params.svh"

module etc_timer_core_tb;
  // Clock, reset and APB master
  logic clock, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  // Pin and status outputs
  logic extEventPin, timerTickOut, matchA, matchB, atTop, atBottom, atMax, countDown;
  logic overflowRequest, compareRequestA, compareRequestB;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  int k;
  logic [32:0] expQ[$]; // Expected {pslverr, prdata}, oldest first
  logic [32:0] note;
  logic [7:0] ec; // Expected count

  etc_timer_core i_dut (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .extEventPin, .timerTickOut, .matchA, .matchB, .atTop,
    .atBottom, .atMax, .countDown, .overflowRequest, .compareRequestA, .compareRequestB);
  etc_event_src i_src (.extEventPin);

  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic end_sim();
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [32:0] got, input logic [32:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Hang guard, well above the fewer than two thousand cycles the run needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      $display("Error at %0t: run timed out", $time);
      end_sim();
    end
  end

  // Each completed access is held against the oldest expectation
  always @(posedge clock) begin
    if (rstn && psel && penable && pready === 1'b1) begin
      note = expQ.pop_front();
      check({pslverr, prdata}, note, "apb");
    end
  end

  // One transfer; the idle edge at the end keeps psel from being set twice at once
  task automatic apb(input logic isWr, input logic [7:0] a, input logic [31:0] dat,
    input logic [32:0] exp);
    expQ.push_back(exp);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= isWr;
    paddr <= a;
    pwdata <= dat;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // The wait ends once pready is high; if it never rises, the hang guard ends the run
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    apb(1'b1, a, dat, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0, {25'h0, e});
  endtask

  task automatic lvl(input logic got, input logic e);
    check({32'h0, got}, {32'h0, e}, "level");
  endtask

  // Pin pulses, then time for the synchroniser to deliver the ticks
  task automatic pulses(input int n);
    i_src.burst(n, n[0]);
    repeat (8) @(posedge clock);
  endtask

  initial begin
    void'($urandom(20592));
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    // Reset values, then refused addresses
    for (int i = 0; i < 8; i++) rd(8'(i * 4), (i == 7) ? 8'h01 : 8'h00);
    apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h02, 32'hff, {1'b1, 32'h0});
    // Byte-wide registers with random upper bits on the bus
    for (int i = 2; i < 5; i++) begin
      d = $urandom();
      wr(8'(i * 4), d);
      rd(8'(i * 4), d[7:0]);
    end
    // Held off by power reduction, then by clock select zero
    wr(`ETC_OFF_COUNT, 32'h21);
    wr(`ETC_OFF_CONTROL_B, 32'h7);
    pulses(3);
    rd(`ETC_OFF_COUNT, 8'h21);
    wr(`ETC_OFF_POWER, 32'h0);
    wr(`ETC_OFF_CONTROL_B, 32'h0);
    pulses(2);
    rd(`ETC_OFF_COUNT, 8'h21);
    ec = 8'h21;
    // Falling then rising pin edge: one tick per pulse
    for (int s = 6; s < 8; s++) begin
      k = 1 + int'($urandom_range(3));
      ec = ec + 8'(k);
      wr(`ETC_OFF_CONTROL_B, 32'(s));
      pulses(k);
      rd(`ETC_OFF_COUNT, ec);
    end
    // Normal wrap; the match right after the count write is blocked
    wr(`ETC_OFF_MASK, 32'h1);
    wr(`ETC_OFF_COMPARE_A, 32'h0);
    wr(`ETC_OFF_COMPARE_B, 32'hfe);
    wr(`ETC_OFF_FLAGS, 32'h7);
    wr(`ETC_OFF_COUNT, 32'hfe);
    pulses(3);
    rd(`ETC_OFF_COUNT, 8'h01);
    rd(`ETC_OFF_FLAGS, 8'h03);
    lvl(overflowRequest, 1'b1);
    lvl(compareRequestA, 1'b0);
    wr(`ETC_OFF_FLAGS, 32'h1);
    rd(`ETC_OFF_FLAGS, 8'h02);
    lvl(overflowRequest, 1'b0);
    wr(`ETC_OFF_MASK, 32'h2);
    rd(`ETC_OFF_MASK, 8'h02);
    lvl(compareRequestA, 1'b1);
    // Clear on compare A
    wr(`ETC_OFF_CONTROL_A, 32'h2);
    wr(`ETC_OFF_COMPARE_A, 32'h3);
    wr(`ETC_OFF_FLAGS, 32'h7);
    wr(`ETC_OFF_COUNT, 32'h0);
    pulses(5);
    rd(`ETC_OFF_COUNT, 8'h01);
    rd(`ETC_OFF_FLAGS, 8'h02);
    wr(`ETC_OFF_COUNT, 32'h3);
    lvl(atTop, 1'b1);
    lvl(matchA, 1'b1);
    wr(`ETC_OFF_COUNT, 32'h0);
    lvl(atBottom, 1'b1);
    // High mode bit turns the same low bits into plain counting
    wr(`ETC_OFF_CONTROL_B, 32'hf);
    wr(`ETC_OFF_COUNT, 32'h2);
    pulses(3);
    rd(`ETC_OFF_COUNT, 8'h05);
    // Fast PWM buffers compare A; normal mode writes straight through
    wr(`ETC_OFF_CONTROL_B, 32'h7);
    wr(`ETC_OFF_CONTROL_A, 32'h3);
    wr(`ETC_OFF_COMPARE_A, 32'h50);
    rd(`ETC_OFF_COMPARE_A, 8'h50);
    wr(`ETC_OFF_COUNT, 32'h50);
    lvl(matchA, 1'b0);
    wr(`ETC_OFF_CONTROL_A, 32'h0);
    wr(`ETC_OFF_COMPARE_A, 32'h50);
    wr(`ETC_OFF_COMPARE_B, 32'h50);
    lvl(matchA, 1'b1);
    lvl(matchB, 1'b1);
    // Phase correct turns down at max
    wr(`ETC_OFF_CONTROL_A, 32'h1);
    wr(`ETC_OFF_COUNT, 32'hfe);
    pulses(3);
    rd(`ETC_OFF_COUNT, 8'hfd);
    lvl(countDown, 1'b1);
    // Free run on the undivided clock with count writes landing on ticks
    wr(`ETC_OFF_MASK, 32'h7);
    wr(`ETC_OFF_CONTROL_B, 32'h1);
    wr(`ETC_OFF_COUNT, 32'h0);
    wr(`ETC_OFF_COUNT, 32'hff);
    wr(`ETC_OFF_COUNT, $urandom());
    repeat (600) @(posedge clock);
    lvl(compareRequestB, 1'b1);
    wr(`ETC_OFF_CONTROL_B, 32'h0);
    repeat (20) @(posedge clock);
    end_sim();
  end
endmodule // etc_timer_core_tb

bind etc_timer_core etc_timer_core_props i_props (.clock, .rstn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .timerTickOut, .atBottom, .atMax,
  .overflowRequest, .compareRequestA);
`default_nettype wire
